//--- adc_ctrl_pkg.sv
// Package: register map, field layout, reset values and counts of the converter control block
package adc_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONV_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h08;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CH_LSB = 0;
  localparam int CH_WIDTH = 5;
  localparam int POS_CONTINUOUS = 5;
  localparam int POS_INT_ENABLE = 6;
  localparam int POS_COMPLETE = 7;
  localparam int POS_MODE10 = 0;
  localparam int POS_CLK_ASYNC = 1;
  localparam int IRQ_BITS = 2;
  localparam int POS_EV_DONE = 0;
  localparam int POS_EV_LOST = 1;

  // ----------------------------------------------------------------
  // Values after reset and codes
  // ----------------------------------------------------------------
  localparam logic [4:0] CHANNEL_OFF = 5'h1f;
  localparam logic [4:0] RST_CHANNEL = 5'h1f;
  localparam logic [1:0] RST_IRQ_MASK = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int SAMPLE_WIDTH = 10;

  // ----------------------------------------------------------------
  // Conversion length in conversion clock ticks
  // ----------------------------------------------------------------
  localparam int CONV_TICKS = 20;

  typedef enum logic [0:0] {
    PH_IDLE = 1'b0,
    PH_DATA = 1'b1
  } bus_phase_type;

endpackage

//--- conv_timer.sv
// Conversion sequencer: counts conversion clock ticks from start to completion
`timescale 1ns/1ps
module conv_timer #(
  parameter int TICKS = adc_ctrl_pkg::CONV_TICKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic start,
  input wire logic abort,
  output logic busy,
  output logic done
);
  import adc_ctrl_pkg::*;

  logic [$clog2(TICKS+1)-1:0] count;

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  // Start wins over abort so a stop-and-restart write begins afresh
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      count <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        count <= '0;
      end else if (abort) begin
        busy <= 1'b0;
      end else if (busy && tick) begin
        if (count == $bits(count)'(TICKS - 1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

endmodule

//--- adc_result_status_control.sv
// Converter control: AHB-Lite registers, completion flag, result byte coherency and interrupt
//
// Behaviour
// - In 10-bit mode a high byte read freezes the low byte.
// - Freeze holds old low byte even when a conversion completes that same cycle.
// - In 8-bit mode the result sits in one byte, no freeze.
// - Single mode keeps the last result until software starts a new conversion.
// - Conversions run from bus clock or asynchronous clock, handed off coherently.
// - On completion load the result and set the completion flag.
// - A control write clears the completion flag, even with coincident completion.
// - Completion during a control write still loads that conversion's result.
// - Enabled interrupt plus set flag raises the interrupt request.
// - Control write selects channel or mode and can stop continuous conversion.
`timescale 1ns/1ps
module adc_result_status_control #(
  parameter int CONV_LEN = adc_ctrl_pkg::CONV_TICKS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic async_conv_clk,
  input wire logic [adc_ctrl_pkg::SAMPLE_WIDTH-1:0] sample_in,
  output logic [4:0] conv_channel,
  output logic conv_active,
  output logic irq
);
  import adc_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bus_phase_type phase;
  logic [7:0] addr_q;
  logic write_q;
  logic continuous;
  logic int_enable;
  logic conversion_complete_flag;
  logic mode10;
  logic clk_async;
  logic [9:0] conversion_result;
  logic [7:0] low_shadow;
  logic low_frozen;
  logic [IRQ_BITS-1:0] irq_status;
  logic [IRQ_BITS-1:0] irq_mask;
  logic [2:0] aclk_sync;
  logic [9:0] samp_s1;
  logic [9:0] samp_s2;
  logic conv_tick;
  logic conv_done;
  logic conv_start;
  logic access;
  logic acc_wr;
  logic acc_rd;
  logic ctrl_wr;
  logic high_rd;
  logic low_rd;
  logic new_off;
  logic [IRQ_BITS-1:0] events;
  logic [31:0] next_rdata;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two stages before use; stage three only feeds the edge detector
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aclk_sync <= 3'h0;
      samp_s1 <= 10'h000;
      samp_s2 <= 10'h000;
    end else begin
      aclk_sync <= {aclk_sync[1:0], async_conv_clk};
      samp_s1 <= sample_in;
      samp_s2 <= samp_s1;
    end
  end

  // Each rising edge of the slow clock is one tick; the bus clock ticks every cycle.
  // The async clock must be well below half the bus rate or ticks are lost.
  assign conv_tick = clk_async ? (aclk_sync[1] & ~aclk_sync[2]) : 1'b1;

  // ----------------------------------------------------------------
  // Bus slave: one wait state so read data come from a flop
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase <= PH_IDLE;
      addr_q <= 8'h00;
      write_q <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      hresp <= 1'b0;
      if (phase == PH_DATA) begin
        phase <= PH_IDLE;
        hreadyout <= 1'b1;
        hrdata <= write_q ? 32'h0000_0000 : next_rdata;
      end else if (hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD) begin
        phase <= PH_DATA;
        addr_q <= haddr;
        write_q <= hwrite;
        hreadyout <= 1'b0;
      end
    end
  end

  // Access strobes in the single cycle the transfer is carried out
  assign access = (phase == PH_DATA);
  assign acc_wr = access & write_q;
  assign acc_rd = access & ~write_q;
  assign ctrl_wr = acc_wr && addr_q == ADDR_CONV_STATUS_CONTROL;
  assign high_rd = acc_rd && addr_q == ADDR_RESULT_HIGH;
  assign low_rd = acc_rd && addr_q == ADDR_RESULT_LOW;
  assign new_off = hwdata[CH_LSB +: CH_WIDTH] == CHANNEL_OFF;

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  // Unmapped addresses read zero and ignore writes
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (addr_q)
      ADDR_CONV_STATUS_CONTROL: begin
        next_rdata[CH_LSB +: CH_WIDTH] = conv_channel;
        next_rdata[POS_CONTINUOUS] = continuous;
        next_rdata[POS_INT_ENABLE] = int_enable;
        next_rdata[POS_COMPLETE] = conversion_complete_flag;
      end
      ADDR_CONFIG: begin
        next_rdata[POS_MODE10] = mode10;
        next_rdata[POS_CLK_ASYNC] = clk_async;
      end
      ADDR_RESULT_HIGH: begin
        next_rdata[1:0] = mode10 ? conversion_result[9:8] : 2'h0;
      end
      ADDR_RESULT_LOW: begin
        next_rdata[7:0] = low_frozen ? low_shadow : conversion_result[7:0];
      end
      ADDR_IRQ_STATUS: begin
        next_rdata[IRQ_BITS-1:0] = irq_status;
      end
      ADDR_IRQ_MASK: begin
        next_rdata[IRQ_BITS-1:0] = irq_mask;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Status and control register
  // ----------------------------------------------------------------
  // Writing the channel field to all ones turns the converter off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_channel <= RST_CHANNEL;
      continuous <= 1'b0;
      int_enable <= 1'b0;
    end else if (ctrl_wr) begin
      conv_channel <= hwdata[CH_LSB +: CH_WIDTH];
      continuous <= hwdata[POS_CONTINUOUS];
      int_enable <= hwdata[POS_INT_ENABLE];
    end
  end

  // Configuration: resolution and conversion clock source
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode10 <= 1'b1;
      clk_async <= 1'b0;
    end else if (acc_wr && addr_q == ADDR_CONFIG) begin
      mode10 <= hwdata[POS_MODE10];
      clk_async <= hwdata[POS_CLK_ASYNC];
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencing
  // ----------------------------------------------------------------
  // Any control write aborts the running sequence; a live channel restarts it.
  // Continuous mode re-arms only while no control write is changing the setup.
  assign conv_start = (ctrl_wr && !new_off) ||
                      (conv_done && continuous && conv_channel != CHANNEL_OFF && !ctrl_wr);

  conv_timer #(
    .TICKS(CONV_LEN)
  ) u_timer (
    .clk(hclk),
    .rst_n(hresetn),
    .tick(conv_tick),
    .start(conv_start),
    .abort(ctrl_wr),
    .busy(conv_active),
    .done(conv_done)
  );

  // ----------------------------------------------------------------
  // Result and completion flag
  // ----------------------------------------------------------------
  // Result loads on every completion, also during a control write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conversion_result <= 10'h000;
    end else if (conv_done) begin
      conversion_result <= mode10 ? samp_s2 : {2'h0, samp_s2[9:2]};
    end
  end

  // The control write wins over a coincident completion, so stopping is clean
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conversion_complete_flag <= 1'b0;
    end else if (ctrl_wr) begin
      conversion_complete_flag <= 1'b0;
    end else if (conv_done) begin
      conversion_complete_flag <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Low byte freeze
  // ----------------------------------------------------------------
  // The shadow samples the result as it stood before this edge, so a completion
  // landing on the same edge as the high read cannot leak its low byte.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_shadow <= 8'h00;
      low_frozen <= 1'b0;
    end else if (high_rd && mode10) begin
      low_shadow <= conversion_result[7:0];
      low_frozen <= 1'b1;
    end else if (low_rd || !mode10) begin
      low_frozen <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, mask and output
  // ----------------------------------------------------------------
  assign events[POS_EV_DONE] = conv_done;
  assign events[POS_EV_LOST] = conv_done & low_frozen;

  // Per bit sticky status; a new event wins over a write-one clear
  genvar gi;
  generate
    for (gi = 0; gi < IRQ_BITS; gi++) begin : g_evt
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          irq_status[gi] <= 1'b0;
        end else if (events[gi]) begin
          irq_status[gi] <= 1'b1;
        end else if (acc_wr && addr_q == ADDR_IRQ_STATUS && hwdata[gi]) begin
          irq_status[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= RST_IRQ_MASK;
    end else if (acc_wr && addr_q == ADDR_IRQ_MASK) begin
      irq_mask <= hwdata[IRQ_BITS-1:0];
    end
  end

  // Registered level: enabled completion flag or any unmasked sticky event
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (conversion_complete_flag & int_enable) | (|(irq_status & irq_mask));
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_done_sets_flag: assert property (conv_done && !ctrl_wr |=> conversion_complete_flag)
    else $error("completion did not set the flag");
  a_result_loaded: assert property (conv_done && mode10 |=> conversion_result == $past(samp_s2))
    else $error("result not loaded on completion");
  a_write_clears: assert property (ctrl_wr |=> !conversion_complete_flag)
    else $error("control write left the flag set");
  a_load_in_write: assert property (ctrl_wr && conv_done |=> conversion_result != 10'h000 ||
                                    $past(samp_s2) == 10'h000)
    else $error("result lost during control write");
  a_low_frozen: assert property (high_rd && mode10 |=>
                                 low_shadow == $past(conversion_result[7:0]) && low_frozen)
    else $error("low byte not frozen from the pre-edge result");
  a_freeze_hold: assert property (low_frozen && !low_rd && !high_rd && mode10 |=> $stable(low_shadow))
    else $error("frozen low byte changed");
  a_high_zero8: assert property (high_rd && !mode10 |=> hrdata == 32'h0000_0000 && hreadyout)
    else $error("high byte not zero in 8-bit mode");
  a_single_hold: assert property (!conv_active && !conv_start && !conv_done |=> $stable(conversion_result))
    else $error("result changed without a conversion");
  a_irq_raise: assert property (conversion_complete_flag && int_enable |=> irq)
    else $error("interrupt not raised");
  a_off_stops: assert property (ctrl_wr && new_off |=> !conv_active ##1 !conv_done)
    else $error("conversion continued after off");
  a_release: assert property (low_rd && mode10 && !high_rd |=> !low_frozen)
    else $error("low read did not release the freeze");
  a_bus_answer: assert property (access |=> hreadyout && !hresp)
    else $error("slave did not answer in one wait state");

  c_done_write: cover property (conv_done && ctrl_wr);
  c_high_read_done: cover property (high_rd && conv_done);
  c_irq: cover property ($rose(irq));
  c_async_conv: cover property (clk_async && conv_done);

endmodule

//--- tb.sv
// Testbench: drives the converter control block over AHB-Lite and checks reads and pins
`timescale 1ns/1ps
module tb;
  import adc_ctrl_pkg::*;
  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  localparam int LEN = 4;
  logic hclk, hresetn, hsel, hwrite, hready, async_conv_clk, rd_pend;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  logic hreadyout, hresp, conv_active, irq;
  logic [SAMPLE_WIDTH-1:0] sample_in;
  logic [4:0] conv_channel;
  logic [9:0] s_a, s_b;
  logic [31:0] exp_q[$];
  string name_q[$];
  int failures, samples_checked;
  // The single slave's answer is the bus's ready
  assign hready = hreadyout;
  adc_result_status_control #(.CONV_LEN(LEN)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .async_conv_clk(async_conv_clk),
    .sample_in(sample_in), .conv_channel(conv_channel), .conv_active(conv_active), .irq(irq)
  );
  // ----------------------------------------------------------------
  // Clocks, compares and bus tasks
  // ----------------------------------------------------------------
  // Bus clock at 100 MHz
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // Conversion clock well below half the bus rate, as the synchroniser needs
  initial begin
    async_conv_clk = 1'b0;
    forever #23 async_conv_clk = ~async_conv_clk;
  end
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic [4:0] e, input logic [4:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Address phase held until ready, then data phase held until ready again
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    hsel <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    name_q.push_back(nm);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Read data is taken at the edge that ends the data phase; pending read noted at the address edge
  always @(posedge hclk) begin
    if (hreadyout === 1'b1) begin
      if (rd_pend) chk32(name_q.pop_front(), exp_q.pop_front(), hrdata);
      rd_pend = hsel && htrans == HTRANS_NONSEQ && !hwrite;
    end
  end
  task automatic close_out;
    $display("Comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Run needs a few hundred cycles; the limit leaves wide margin for a hung handshake
  initial begin
    #50_000;
    failures++;
    $display("Watchdog expired before the sequence ended");
    close_out();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0000_0000;
    sample_in = 10'h000;
    rd_pend = 1'b0;
    failures = 0;
    samples_checked = 0;
    void'($urandom(89517));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values and an unmapped place
    rd("ctrl reset", ADDR_CONV_STATUS_CONTROL, 32'h0000_001f);
    rd("config reset", ADDR_CONFIG, 32'h0000_0001);
    rd("mask reset", ADDR_IRQ_MASK, 32'h0000_0000);
    rd("status reset", ADDR_IRQ_STATUS, 32'h0000_0000);
    wr(8'h18, $urandom);
    rd("unmapped", 8'h18, 32'h0000_0000);
    chk_pin("hresp", 5'h00, {4'h0, hresp});
    // Single 10-bit conversion; result must hold while the pins move on
    s_a = 10'($urandom);
    sample_in <= s_a;
    cyc(4);
    wr(ADDR_CONV_STATUS_CONTROL, 32'h0000_0043);
    cyc(8);
    chk_pin("irq flag", 5'h01, {4'h0, irq});
    chk_pin("channel", 5'h03, conv_channel);
    rd("ctrl done", ADDR_CONV_STATUS_CONTROL, 32'h0000_00c3);
    sample_in <= ~s_a;
    cyc(8);
    rd("single high", ADDR_RESULT_HIGH, {30'h0, s_a[9:8]});
    rd("single low", ADDR_RESULT_LOW, {24'h0, s_a[7:0]});
    // Turning off clears the flag and nothing restarts
    wr(ADDR_CONV_STATUS_CONTROL, 32'h0000_001f);
    cyc(1);
    chk_pin("irq off", 5'h00, {4'h0, irq});
    chk_pin("channel off", 5'h1f, conv_channel);
    cyc(10);
    rd("ctrl off", ADDR_CONV_STATUS_CONTROL, 32'h0000_001f);
    chk_pin("idle", 5'h00, {4'h0, conv_active});
    // Sticky status, mask and write-one clear
    rd("status done", ADDR_IRQ_STATUS, 32'h0000_0001);
    wr(ADDR_IRQ_MASK, 32'h0000_0003);
    cyc(1);
    chk_pin("irq masked in", 5'h01, {4'h0, irq});
    wr(ADDR_IRQ_STATUS, 32'h0000_0001);
    cyc(1);
    chk_pin("irq cleared", 5'h00, {4'h0, irq});
    // Continuous run: high read freezes the low byte, low read releases it
    s_b = ~s_a;
    sample_in <= s_a;
    wr(ADDR_CONV_STATUS_CONTROL, 32'h0000_0022);
    cyc(10);
    rd("cont high", ADDR_RESULT_HIGH, {30'h0, s_a[9:8]});
    sample_in <= s_b;
    cyc(12);
    rd("frozen low", ADDR_RESULT_LOW, {24'h0, s_a[7:0]});
    rd("next high", ADDR_RESULT_HIGH, {30'h0, s_b[9:8]});
    rd("next low", ADDR_RESULT_LOW, {24'h0, s_b[7:0]});
    chk_pin("irq lost", 5'h01, {4'h0, irq});
    rd("status lost", ADDR_IRQ_STATUS, 32'h0000_0003);
    wr(ADDR_CONV_STATUS_CONTROL, 32'h0000_001f);
    wr(ADDR_IRQ_STATUS, 32'h0000_0003);
    cyc(10);
    chk_pin("stopped", 5'h00, {4'h0, conv_active});
    // Eight-bit mode: one byte, no freeze between reads
    wr(ADDR_CONFIG, 32'h0000_0000);
    wr(ADDR_CONV_STATUS_CONTROL, 32'h0000_0005);
    cyc(8);
    rd("8b high", ADDR_RESULT_HIGH, 32'h0000_0000);
    sample_in <= s_a;
    cyc(4);
    wr(ADDR_CONV_STATUS_CONTROL, 32'h0000_0005);
    cyc(8);
    rd("8b low", ADDR_RESULT_LOW, {24'h0, s_a[9:2]});
    // Conversion timed by the asynchronous clock
    wr(ADDR_CONFIG, 32'h0000_0003);
    sample_in <= s_b;
    cyc(4);
    wr(ADDR_CONV_STATUS_CONTROL, 32'h0000_0006);
    cyc(5);
    chk_pin("async busy", 5'h01, {4'h0, conv_active});
    cyc(40);
    rd("async high", ADDR_RESULT_HIGH, {30'h0, s_b[9:8]});
    rd("async low", ADDR_RESULT_LOW, {24'h0, s_b[7:0]});
    // Stop write landing on, and after, the completing edge
    wr(ADDR_CONFIG, 32'h0000_0001);
    // One cycle less and the stop write aborts the conversion before it completes
    for (int k = 2; k < 5; k++) begin
      s_a = 10'($urandom);
      sample_in <= s_a;
      cyc(4);
      wr(ADDR_CONV_STATUS_CONTROL, 32'h0000_0004);
      cyc(k);
      wr(ADDR_CONV_STATUS_CONTROL, 32'h0000_001f);
      rd("flag after stop", ADDR_CONV_STATUS_CONTROL, 32'h0000_001f);
      rd("stop high", ADDR_RESULT_HIGH, {30'h0, s_a[9:8]});
      rd("stop low", ADDR_RESULT_LOW, {24'h0, s_a[7:0]});
    end
    cyc(2);
    chk32("reads left", 32'h0000_0000, exp_q.size());
    close_out();
  end
endmodule
